// File: hw/phy_cfg_regs.sv
// Transceiver configuration bank: self-test, delay, equalizer, trims
//
// Contract
// RULE1 - Every self-test packet carries exactly the programmed length; reset 1500 bytes.
// RULE2 - Each packet starts with thirteen 0x5 nibbles then delimiter byte 0xD5.
// RULE3 - An idle gap separates packets; gap field resets to 0x7D (500 bytes).
// RULE4 - Gap length in bytes is four times the gap field.
// RULE5 - Receive equalizer word is read-write, resets to zero.
// RULE6 - Transmit delay code in bits 7:4 gives (code+1) quarter nanoseconds.
// RULE7 - Receive delay code in bits 3:0 gives quarter-nanosecond steps, 0.25 to 4.00.
// RULE8 - Receive delay uses the same monotonic code+1 quarter-ns encoding.
// RULE9 - With strapping selected, low three bits of each delay load from straps.
// RULE10 - Delay register bits 15:8 ignore writes and read as zero.
// RULE11 - Fine gain code steps two percent; 0 is -16%, 8 neutral.
// RULE12 - Fine gain resets from factory trim and stays writable.
// RULE13 - Gains A,B in bits 3:0,11:8 of one register; C,D likewise next.
// RULE14 - Channel A/B swing value applies only while its override bit is set.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module phy_cfg_regs (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   input  wire logic        strapSelect,
   input  wire logic [2:0]  strapTxDelay,
   input  wire logic [2:0]  strapRxDelay,
   input  wire logic [15:0] trimGain,
   input  wire logic [4:0]  autoSwingA,
   input  wire logic [4:0]  autoSwingB,
   output var  logic [4:0]  txDelaySteps,
   output var  logic [4:0]  rxDelaySteps,
   output var  logic [23:0] gainPercent,
   output var  logic [4:0]  swingA,
   output var  logic [4:0]  swingB,
   output var  logic [15:0] eqWord,
   output logic [3:0]       selftestNibble,
   output logic             selftestValid
);
   // Register state
   phy_cfg_pkg::word_t pktLen;
   logic [7:0]         gapField;
   logic [3:0]         txDelay;
   logic [3:0]         rxDelay;
   logic [3:0]         gainCode [4];
   logic [4:0]         swingValA;
   logic [4:0]         swingValB;
   logic               overrideA;
   logic               overrideB;
   logic               selftestEnable;
   // Bus holding state
   logic [11:0]        awAddrQ;
   logic [15:0]        wDataQ;
   logic [1:0]         wStrbQ;
   // Pin synchronisers and strap loader
   logic [22:0]        pinMeta;
   logic [22:0]        pinSync;
   logic [1:0]         loadCnt;
   // Decode and read path
   logic               doWrite;
   logic               loadNow;
   logic               strapOn;
   logic [2:0]         syncTx;
   logic [2:0]         syncRx;
   logic [15:0]        syncTrim;
   logic [15:0]        wMask;
   logic [15:0]        wMerged;
   logic               wrLen;
   logic               wrGap;
   logic               wrDelay;
   logic               wrEq;
   logic               wrGainAB;
   logic               wrGainCD;
   logic               wrSwing;
   logic               wrCtrl;
   logic               wrHit;
   phy_cfg_pkg::word_t rdDelay;
   phy_cfg_pkg::word_t rdGainAB;
   phy_cfg_pkg::word_t rdGainCD;
   phy_cfg_pkg::word_t rdSwing;
   logic [11:0]        rdIdx;
   logic [31:0]        rdMux;
   logic               rdHit;

   selftest_if st ();

   selftest_gen u_gen (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .st       (st.gen)
   );

   assign st.enable      = selftestEnable;
   assign st.pktLen      = pktLen;
   assign st.gapField    = gapField;
   assign selftestNibble = st.nibble;
   assign selftestValid  = st.nibbleValid;

   // Pins are asynchronous to the core clock: two flops before use
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinMeta <= 23'h000000;
         pinSync <= 23'h000000;
      end else begin
         pinMeta <= {strapSelect, strapTxDelay, strapRxDelay, trimGain};
         pinSync <= pinMeta;
      end
   end

   assign strapOn  = pinSync[22];
   assign syncTx   = pinSync[21:19];
   assign syncRx   = pinSync[18:16];
   assign syncTrim = pinSync[15:0];

   // Straps and trim are taken once the synchroniser has filled, never
   // from the raw pin under reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         loadCnt <= 2'h0;
      end else if (loadCnt != 2'h3) begin
         loadCnt <= 2'(loadCnt + 2'h1);
      end
   end

   assign loadNow = (loadCnt == `STRAP_SETTLE);

   // Write decode; byte lanes 0 and 1 cover the 16-bit registers
   assign doWrite  = !awready && !wready && !bvalid;
   assign wrLen    = doWrite && (awAddrQ == `ADDR_PKT_LEN);
   assign wrGap    = doWrite && (awAddrQ == `ADDR_GAP_LEN);
   assign wrDelay  = doWrite && (awAddrQ == `ADDR_CLK_DELAY);
   assign wrEq     = doWrite && (awAddrQ == `ADDR_EQ_CFG);
   assign wrGainAB = doWrite && (awAddrQ == `ADDR_GAIN_AB);
   assign wrGainCD = doWrite && (awAddrQ == `ADDR_GAIN_CD);
   assign wrSwing  = doWrite && (awAddrQ == `ADDR_SWING_AB);
   assign wrCtrl   = doWrite && (awAddrQ == `ADDR_ST_CTRL);
   assign wrHit    = wrLen || wrGap || wrDelay || wrEq || wrGainAB ||
                     wrGainCD || wrSwing || wrCtrl;
   assign wMask    = {{8{wStrbQ[1]}}, {8{wStrbQ[0]}}};

   // Self-test length, gap and control
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pktLen         <= `RST_PKT_LEN;                    // RULE1
         gapField       <= `RST_GAP_FIELD;                  // RULE3
         selftestEnable <= 1'b0;
      end else begin
         if (wrLen) begin
            pktLen <= (pktLen & ~wMask) | (wDataQ & wMask); // RULE1
         end
         if (wrGap && wStrbQ[0]) begin
            gapField <= wDataQ[7:0];                        // RULE4
         end
         if (wrCtrl && wStrbQ[0]) begin
            selftestEnable <= wDataQ[0];
         end
      end
   end

   // Equalizer word drives the receiver directly
   assign wMerged = (eqWord & ~wMask) | (wDataQ & wMask);
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         eqWord <= `RST_EQ_WORD;                            // RULE5
      end else if (wrEq) begin
         eqWord <= wMerged;                                 // RULE5
      end
   end

   // Clock delay codes; the strap load fills the low three bits and clears bit 3
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txDelay <= `RST_DELAY_CODE;
         rxDelay <= `RST_DELAY_CODE;
      end else if (loadNow && strapOn) begin
         txDelay <= {1'b0, syncTx};                         // RULE9
         rxDelay <= {1'b0, syncRx};                         // RULE9
      end else if (wrDelay && wStrbQ[0]) begin
         txDelay <= wDataQ[`TX_DLY_LSB +: 4];               // RULE6 RULE10
         rxDelay <= wDataQ[3:0];                            // RULE7 RULE10
      end
   end

   // Delay outputs in quarter-ns units, code plus one on both paths
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txDelaySteps <= 5'h00;
         rxDelaySteps <= 5'h00;
      end else begin
         txDelaySteps <= 5'({1'b0, txDelay} + 5'h01);       // RULE6
         rxDelaySteps <= 5'({1'b0, rxDelay} + 5'h01);       // RULE7 RULE8
      end
   end

   // Fine gain per channel: even channels low nibble, odd ones bits 11:8
   for (genvar ch = 0; ch < 4; ch++) begin : g_gain
      localparam int LSB = (ch % 2) * `CHAN_B_LSB;
      logic wrSel;
      assign wrSel = (ch < 2) ? wrGainAB : wrGainCD;        // RULE13
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            gainCode[ch] <= `RST_GAIN_CODE;
         end else if (loadNow) begin
            gainCode[ch] <= syncTrim[ch*4 +: 4];            // RULE12
         end else if (wrSel && wStrbQ[ch % 2]) begin
            gainCode[ch] <= wDataQ[LSB +: 4];               // RULE12 RULE13
         end
      end
      // Percent change is twice the code, offset so code 8 is neutral
      always_ff @(posedge core_clk or negedge arst_n) begin
         if (!arst_n) begin
            gainPercent[ch*6 +: 6] <= 6'h00;
         end else begin
            gainPercent[ch*6 +: 6] <=
               6'({1'b0, gainCode[ch], 1'b0} - 6'h10);      // RULE11
         end
      end
   end

   // Line-driver swing values and their override bits
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         swingValA <= `RST_SWING_A;
         swingValB <= `RST_SWING_B;
         overrideA <= 1'b0;
         overrideB <= 1'b0;
      end else if (wrSwing) begin
         if (wStrbQ[0]) begin
            swingValA <= wDataQ[4:0];
            overrideA <= wDataQ[`OVR_BIT];
         end
         if (wStrbQ[1]) begin
            swingValB <= wDataQ[`CHAN_B_LSB +: 5];
            overrideB <= wDataQ[`CHAN_B_LSB + `OVR_BIT];
         end
      end
   end

   // Without an override the internally chosen swing passes through
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         swingA <= `RST_SWING_A;
         swingB <= `RST_SWING_B;
      end else begin
         swingA <= overrideA ? swingValA : autoSwingA;      // RULE14
         swingB <= overrideB ? swingValB : autoSwingB;      // RULE14
      end
   end

   // Write channels: address and data taken in either order, then B
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         awAddrQ <= 12'h000;
         wDataQ  <= 16'h0000;
         wStrbQ  <= 2'h0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end else begin
         if (awready && awvalid) begin
            awready <= 1'b0;
            awAddrQ <= {awaddr[11:2], 2'b00};
         end
         if (wready && wvalid) begin
            wready <= 1'b0;
            wDataQ <= wdata[15:0];
            wStrbQ <= wstrb[1:0];
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? `RESP_OKAY : `RESP_DECERR;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Read decode; reserved bits read as zero
   assign rdDelay  = {8'h00, txDelay, rxDelay};             // RULE10
   assign rdGainAB = {4'h0, gainCode[1], 4'h0, gainCode[0]};
   assign rdGainCD = {4'h0, gainCode[3], 4'h0, gainCode[2]};
   assign rdSwing  = {2'h0, overrideB, swingValB,
                      2'h0, overrideA, swingValA};
   assign rdIdx    = {2'b00, araddr[11:2]};
   assign rdHit    = (rdIdx == `IDX_PKT_LEN) ||
                     (rdIdx == `IDX_GAP_LEN) ||
                     (rdIdx == `IDX_CLK_DELAY) ||
                     (rdIdx == `IDX_EQ_CFG) ||
                     (rdIdx == `IDX_GAIN_AB) ||
                     (rdIdx == `IDX_GAIN_CD) ||
                     (rdIdx == `IDX_SWING_AB) ||
                     (rdIdx == `IDX_ST_CTRL) ||
                     (rdIdx == `IDX_ST_STATUS);
   assign rdMux =
      (rdIdx == `IDX_PKT_LEN)   ? {16'h0000, pktLen}          :
      (rdIdx == `IDX_GAP_LEN)   ? {24'h000000, gapField}      :
      (rdIdx == `IDX_CLK_DELAY) ? {16'h0000, rdDelay}         :
      (rdIdx == `IDX_EQ_CFG)    ? {16'h0000, eqWord}          :
      (rdIdx == `IDX_GAIN_AB)   ? {16'h0000, rdGainAB}        :
      (rdIdx == `IDX_GAIN_CD)   ? {16'h0000, rdGainCD}        :
      (rdIdx == `IDX_SWING_AB)  ? {16'h0000, rdSwing}         :
      (rdIdx == `IDX_ST_CTRL)   ? {31'h00000000,
                                   selftestEnable}            :
      (rdIdx == `IDX_ST_STATUS) ? {15'h0000, st.busy,
                                   st.packetCount}            :
                                  32'h00000000;

   // Read channel: one register stage, data held until taken
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `RESP_OKAY;
      end else if (arready && arvalid) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rdMux;
         rresp   <= rdHit ? `RESP_OKAY : `RESP_DECERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: hw/phy_cfg_defs.svh
// Offsets, reset values and counts of the transceiver configuration bank
`ifndef PHY_CFG_DEFS_SVH
`define PHY_CFG_DEFS_SVH
// Register indices as printed; byte address is four times the index
`define IDX_PKT_LEN      12'h07B
`define IDX_GAP_LEN      12'h07C
`define IDX_CLK_DELAY    12'h086
`define IDX_EQ_CFG       12'h08A
`define IDX_GAIN_AB      12'h0A0
`define IDX_GAIN_CD      12'h0A1
`define IDX_SWING_AB     12'h0A2
`define IDX_ST_CTRL      12'h0C0
`define IDX_ST_STATUS    12'h0C1
`define ADDR_PKT_LEN     12'(`IDX_PKT_LEN * 12'h004)
`define ADDR_GAP_LEN     12'(`IDX_GAP_LEN * 12'h004)
`define ADDR_CLK_DELAY   12'(`IDX_CLK_DELAY * 12'h004)
`define ADDR_EQ_CFG      12'(`IDX_EQ_CFG * 12'h004)
`define ADDR_GAIN_AB     12'(`IDX_GAIN_AB * 12'h004)
`define ADDR_GAIN_CD     12'(`IDX_GAIN_CD * 12'h004)
`define ADDR_SWING_AB    12'(`IDX_SWING_AB * 12'h004)
`define ADDR_ST_CTRL     12'(`IDX_ST_CTRL * 12'h004)
`define ADDR_ST_STATUS   12'(`IDX_ST_STATUS * 12'h004)
// Reset values
`define RST_PKT_LEN      16'h05DC
`define RST_GAP_FIELD    8'h7D
`define RST_EQ_WORD      16'h0000
`define RST_DELAY_CODE   4'h7
`define RST_GAIN_CODE    4'h8
`define RST_SWING_A      5'h10
`define RST_SWING_B      5'h08
// Field positions
`define TX_DLY_LSB       4
`define CHAN_B_LSB       8
`define OVR_BIT          5
// Self-test framing
`define PRE_NIBBLES      4'hD
`define PRE_NIBBLE       4'h5
`define SFD_BYTE         8'hD5
// Strap settle: edges after reset release before straps are taken
`define STRAP_SETTLE     2'h2
// AXI responses
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3
`endif

// File: hw/phy_cfg_pkg.sv
// Types shared by the configuration bank and its self-test generator
package phy_cfg_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [2:0] {
      GEN_IDLE   = 3'b000,
      GEN_PRE    = 3'b001,
      GEN_SFD_LO = 3'b010,
      GEN_SFD_HI = 3'b011,
      GEN_DATA   = 3'b100,
      GEN_GAP    = 3'b101
   } gen_state_e;
endpackage

// File: hw/selftest_if.sv
// Link between the register bank and the self-test generator
`timescale 1ns/1ps
`default_nettype none
interface selftest_if;
   logic                enable;
   phy_cfg_pkg::word_t  pktLen;
   logic [7:0]          gapField;
   logic [3:0]          nibble;
   logic                nibbleValid;
   logic                busy;
   phy_cfg_pkg::word_t  packetCount;
   modport ctrl (output enable, output pktLen, output gapField,
                 input nibble, input nibbleValid, input busy,
                 input packetCount);
   modport gen  (input enable, input pktLen, input gapField,
                 output nibble, output nibbleValid, output busy,
                 output packetCount);
endinterface
`default_nettype wire

// File: hw/selftest_gen.sv
// Self-test packet generator: preamble, delimiter, payload, idle gap
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module selftest_gen (
   input wire logic  core_clk,
   input wire logic  arst_n,
   selftest_if.gen   st
);
   phy_cfg_pkg::gen_state_e state;
   phy_cfg_pkg::word_t      cnt;
   phy_cfg_pkg::word_t      lenQ;
   logic [10:0]             gapQ;
   logic                    phase;
   logic [3:0]              nibble;
   logic                    nibbleValid;
   phy_cfg_pkg::word_t      packetCount;
   logic [7:0]              dataByte;
   logic                    lastByte;
   logic                    gapDone;

   // Payload is the running byte index; gap counts nibble times
   assign dataByte = cnt[7:0];
   assign lastByte = (16'(cnt + 16'h0001) == lenQ);
   assign gapDone  = (11'(cnt[10:0] + 11'h001) >= gapQ);
   assign st.nibble      = nibble;
   assign st.nibbleValid = nibbleValid;
   assign st.busy        = (state != phy_cfg_pkg::GEN_IDLE);
   assign st.packetCount = packetCount;

   // Framing sequencer; settings are latched per packet so a write
   // mid-packet never produces a torn frame
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= phy_cfg_pkg::GEN_IDLE;
         cnt         <= 16'h0000;
         lenQ        <= 16'h0000;
         gapQ        <= 11'h000;
         phase       <= 1'b0;
         nibble      <= 4'h0;
         nibbleValid <= 1'b0;
         packetCount <= 16'h0000;
      end else begin
         case (state)
            phy_cfg_pkg::GEN_IDLE, phy_cfg_pkg::GEN_GAP: begin
               if (state == phy_cfg_pkg::GEN_GAP && !gapDone) begin
                  cnt <= 16'(cnt + 16'h0001);
               end else if (st.enable) begin
                  state       <= phy_cfg_pkg::GEN_PRE;      // RULE2
                  cnt         <= 16'h0001;
                  lenQ        <= st.pktLen;                 // RULE1
                  gapQ        <= {st.gapField, 3'b000};     // RULE3 RULE4
                  nibble      <= `PRE_NIBBLE;
                  nibbleValid <= 1'b1;
               end else begin
                  state <= phy_cfg_pkg::GEN_IDLE;
               end
            end
            phy_cfg_pkg::GEN_PRE: begin
               if (cnt[3:0] == `PRE_NIBBLES) begin
                  state  <= phy_cfg_pkg::GEN_SFD_LO;
                  nibble <= 4'(`SFD_BYTE & 8'h0F);          // RULE2
               end else begin
                  cnt    <= 16'(cnt + 16'h0001);
                  nibble <= `PRE_NIBBLE;
               end
            end
            phy_cfg_pkg::GEN_SFD_LO: begin
               state  <= phy_cfg_pkg::GEN_SFD_HI;
               nibble <= 4'(`SFD_BYTE >> 4);                // RULE2
            end
            phy_cfg_pkg::GEN_SFD_HI: begin
               cnt   <= 16'h0000;
               phase <= 1'b0;
               if (lenQ == 16'h0000) begin
                  state       <= phy_cfg_pkg::GEN_GAP;
                  nibbleValid <= 1'b0;
                  packetCount <= 16'(packetCount + 16'h0001);
               end else begin
                  state  <= phy_cfg_pkg::GEN_DATA;
                  nibble <= 4'h0;
               end
            end
            phy_cfg_pkg::GEN_DATA: begin
               if (!phase) begin
                  phase  <= 1'b1;
                  nibble <= dataByte[7:4];
               end else if (lastByte) begin
                  state       <= phy_cfg_pkg::GEN_GAP;      // RULE1 RULE3
                  cnt         <= 16'h0000;
                  nibbleValid <= 1'b0;
                  packetCount <= 16'(packetCount + 16'h0001);
               end else begin
                  cnt    <= 16'(cnt + 16'h0001);
                  phase  <= 1'b0;
                  nibble <= 4'(16'(cnt + 16'h0001));
               end
            end
            default: begin
               state       <= phy_cfg_pkg::GEN_IDLE;
               nibbleValid <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: dv/phy_cfg_regs_properties.sv
// Port checks for the transceiver configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module phy_cfg_regs_properties (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic [11:0] araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [4:0]  txDelaySteps,
   input wire logic [4:0]  rxDelaySteps,
   input wire logic [23:0] gainPercent,
   input wire logic [4:0]  swingA,
   input wire logic [4:0]  autoSwingA,
   input wire logic [15:0] eqWord,
   input wire logic [3:0]  selftestNibble,
   input wire logic        selftestValid
);
   logic [11:0] rdAddr;
   // Remember the address the pending read answers for
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) rdAddr <= 12'h000;
      else if (arvalid && arready) rdAddr <= araddr;
   end
   // Readback of a register ties its value to the live outputs
   wire rdDly = rvalid && rdAddr == `ADDR_CLK_DELAY;
   wire rdGain = rvalid && rdAddr == `ADDR_GAIN_AB;
   wire rdSwing = rvalid && rdAddr == `ADDR_SWING_AB;
   wire rdEq = rvalid && rdAddr == `ADDR_EQ_CFG;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_pre7;
      (selftestValid && selftestNibble == 4'h5) [*7];
   endsequence
   property p_pre;
      $rose(selftestValid) |-> s_pre7 ##1 s_pre7 ##1 selftestNibble == 4'hD;
   endproperty
   property p_txDly;
      rdDly |-> txDelaySteps == 5'(rdata[7:4]) + 5'h01;
   endproperty
   property p_rxDly;
      rdDly |-> rxDelaySteps == 5'(rdata[3:0]) + 5'h01;
   endproperty
   property p_dlyRsvd;
      rdDly |-> rdata[15:8] == 8'h00;
   endproperty
   property p_gain;
      rdGain |-> gainPercent[5:0] == (6'(rdata[3:0]) << 1) - 6'h10
         && gainPercent[11:6] == (6'(rdata[11:8]) << 1) - 6'h10;
   endproperty
   property p_swing;
      rdSwing |-> swingA == (rdata[5] ? rdata[4:0] : $past(autoSwingA));
   endproperty
   property p_eq;
      rdEq |-> rdata[15:0] == eqWord;
   endproperty
   property p_rAns;
      arvalid && arready |=> rvalid;
   endproperty
   property p_rHold;
      rvalid && !rready |=> rvalid && $stable(rdata);
   endproperty
   a_pre: assert property (p_pre) else $error("bad preamble");
   a_txDly: assert property (p_txDly) else $error("tx delay");
   a_rxDly: assert property (p_rxDly) else $error("rx delay");
   a_dlyRsvd: assert property (p_dlyRsvd) else $error("reserved");
   a_gain: assert property (p_gain) else $error("gain");
   a_swing: assert property (p_swing) else $error("swing");
   a_eq: assert property (p_eq) else $error("eq word");
   a_rAns: assert property (p_rAns) else $error("no read answer");
   a_rHold: assert property (p_rHold) else $error("read not held");
endmodule
bind phy_cfg_regs phy_cfg_regs_properties chk (.core_clk, .arst_n,
   .araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .txDelaySteps,
   .rxDelaySteps, .gainPercent, .swingA, .autoSwingA, .eqWord,
   .selftestNibble, .selftestValid);
`default_nettype wire

// File: dv/strap_trim_source.sv
// Strap pins, factory trim and internal swing choice seen by the bank
`timescale 1ns/1ps
`default_nettype none
module strap_trim_source (
   output var logic        strapSelect,
   output var logic [2:0]  strapTxDelay,
   output var logic [2:0]  strapRxDelay,
   output var logic [15:0] trimGain,
   output var logic [4:0]  autoSwingA,
   output var logic [4:0]  autoSwingB
);
   // Resistors and fuses never move, so the bank sees steady levels
   assign strapSelect = 1'b1;
   assign strapTxDelay = 3'h5;
   assign strapRxDelay = 3'h2;
   assign trimGain = 16'h9A3C;
   assign autoSwingA = 5'h13;
   assign autoSwingB = 5'h07;
endmodule
`default_nettype wire

// File: dv/phy_cfg_regs_bench.sv
// Directed bench for the configuration bank over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "phy_cfg_defs.svh"
module phy_cfg_regs_bench;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awready, wready, bvalid, arready, rvalid, selftestValid;
   logic        strapSelect;
   logic [1:0]  bresp, rresp;
   logic [2:0]  strapTxDelay, strapRxDelay;
   logic [15:0] trimGain, eqWord;
   logic [4:0]  autoSwingA, autoSwingB, txDelaySteps, rxDelaySteps, swingA;
   logic [4:0]  swingB;
   logic [23:0] gainPercent;
   logic [3:0]  selftestNibble;
   int          errorCnt = 0, checksDone = 0, cycles = 0, n;
   always #5 core_clk = ~core_clk;
   phy_cfg_regs uut (.core_clk, .arst_n, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'h3), .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .strapSelect, .strapTxDelay, .strapRxDelay, .trimGain, .autoSwingA,
      .autoSwingB, .txDelaySteps, .rxDelaySteps, .gainPercent, .swingA,
      .swingB, .eqWord, .selftestNibble, .selftestValid);
   strap_trim_source far (.strapSelect, .strapTxDelay, .strapRxDelay,
      .trimGain, .autoSwingA, .autoSwingB);
   task automatic testDone;
      $display("errors %0d checks %0d", errorCnt, checksDone);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Address and data go out together; each drops once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = `RESP_OKAY);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er), "bresp");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er = `RESP_OKAY);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, e, "rdata");
      chk(32'(rresp), 32'(er), "rresp");
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errorCnt++;
         testDone;
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(`ADDR_PKT_LEN, 32'h05DC);
      rd(`ADDR_GAP_LEN, 32'h007D);
      rd(`ADDR_EQ_CFG, 32'h0000);
      rd(`ADDR_CLK_DELAY, 32'h0052);
      rd(`ADDR_GAIN_AB, 32'h030C);
      rd(`ADDR_GAIN_CD, 32'h090A);
      wr(`ADDR_EQ_CFG, 32'h010F);
      rd(`ADDR_EQ_CFG, 32'h010F);
      wr(`ADDR_CLK_DELAY, 32'hFFF4);
      rd(`ADDR_CLK_DELAY, 32'h00F4);
      chk(32'(txDelaySteps), 32'd16, "tx delay");
      chk(32'(rxDelaySteps), 32'd5, "rx delay");
      wr(`ADDR_GAIN_AB, 32'h0F00);
      rd(`ADDR_GAIN_AB, 32'h0F00);
      chk(32'(gainPercent[11:0]), 32'h3B0, "gain");
      wr(`ADDR_SWING_AB, 32'h2A25);
      rd(`ADDR_SWING_AB, 32'h2A25);
      chk(32'({swingB, swingA}), 32'h145, "swing forced");
      wr(`ADDR_SWING_AB, 32'h0A05);
      rd(`ADDR_SWING_AB, 32'h0A05);
      chk(32'({swingB, swingA}), 32'h0F3, "swing auto");
      wr(12'h004, 32'h1, `RESP_DECERR);
      rd(12'h004, 32'h0, `RESP_DECERR);
      wr(`ADDR_PKT_LEN, 32'h3);
      wr(`ADDR_GAP_LEN, 32'h1);
      wr(`ADDR_ST_CTRL, 32'h1);
      do @(posedge core_clk); while (selftestValid !== 1'b1);
      n = 0;
      while (selftestValid === 1'b1) begin
         n++;
         @(posedge core_clk);
      end
      chk(32'(n), 32'd21, "packet nibbles");
      n = 0;
      while (selftestValid === 1'b0) begin
         n++;
         @(posedge core_clk);
      end
      chk(32'(n), 32'd8, "gap cycles");
      testDone;
   end
endmodule
`default_nettype wire
